// [core/ccs_params.svh]
// Constants for the cycle sequencer block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
// ************************************
// Timing
// ************************************
`define CCS_OSC_NS 10
`define CCS_PHASES 12
`define CCS_LAST 4'hb
`define CCS_S1P2 4'h1
`define CCS_S2P1 4'h2
`define CCS_S3P2 4'h5
`define CCS_S4P1 4'h6
`define CCS_S4P2 4'h7
`define CCS_S5P1 4'h8
`define CCS_S6P1 4'ha
`define CCS_SIG_END 4'h6
// ************************************
// Registers (word index)
// ************************************
`define CCS_R_CTRL 4'h0
`define CCS_R_STAT 4'h1
`define CCS_R_PSW 4'h2
`define CCS_R_ACC 4'h3
`define CCS_R_DPTR 4'h4
`define CCS_R_LATCH 4'h5
`define CCS_R_PIN 4'h6
`define CCS_R_PC 4'h7
`define CCS_PSW_RST 8'h00
`define CCS_PSW_WMASK 8'hfc
`define CCS_LATCH_RST 8'hff
// ************************************
// Opcodes
// ************************************
`define CCS_OP_MUL 8'ha4
`define CCS_OP_DIV 8'h84
`define CCS_EXTERNAL_DATA_MOVE_TOP 3'h7
`define CCS_CYC_MULDIV 3'h4
`define CCS_CYC_LONG 3'h2
`define CCS_CYC_ONE 3'h1
`endif

// [core/ccs_pkg.sv]
// Types for the cycle sequencer block
package ccs_pkg;
   typedef enum logic [2:0] {
      ccs_idle = 3'b001,
      ccs_exec = 3'b010,
      ccs_xmem = 3'b100
   } ccs_run_t;
endpackage

// [core/ccs_timing_if.sv]
// Phase and state timing shared inside the block
`timescale 1ns/1ps
interface ccs_timing_if (
   input wire logic clk
);
   logic [3:0] phase_idx;
   logic phase_one;
   logic [2:0] state_num;
   modport gen (output phase_idx, output phase_one, output state_num);
   modport mon (input phase_idx, input phase_one, input state_num);
endinterface

// [core/ccs_phase_gen.sv]
// Phase, state and machine cycle generator
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_phase_gen (
   input wire logic clk_sys,
   input wire logic rst_b,
   ccs_timing_if.gen tim
);
   logic [3:0] idx_ff;
   // ************************************
   // Phase counter, one step per period
   // ************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         idx_ff <= 4'h0;
      end else if (idx_ff == `CCS_LAST) begin
         idx_ff <= 4'h0;
      end else begin
         idx_ff <= idx_ff + 4'h1;
      end
   end
   assign tim.phase_idx = idx_ff;
   assign tim.phase_one = ~idx_ff[0];
   assign tim.state_num = idx_ff[3:1] + 3'h1;

   phase_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      idx_ff == `CCS_LAST |=> idx_ff == 4'h0)
      else $error("Machine cycle not 12 periods");
   state_half_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(tim.state_num) |=> $stable(tim.state_num) ##1 $changed(tim.state_num))
      else $error("State not two periods long");
endmodule

// [core/ccs_port.sv]
// One 8-bit port: latch, output stage, pin sampling
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_port #(
   parameter int W = 8,
   parameter bit ONES_ON_BUS = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   ccs_timing_if.mon tim,
   input wire logic latch_wr,
   input wire logic [W-1:0] wdata,
   input wire logic rd_pin,
   input wire logic bus_oe,
   input wire logic [W-1:0] bus_data,
   input wire logic [W-1:0] alt_out,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out_ff,
   output logic [W-1:0] pin_oe_ff,
   output logic [W-1:0] pin_sync_ff,
   output logic [W-1:0] rd_value
);
   logic [W-1:0] latch_ff;
   logic [W-1:0] meta_ff;
   logic [W-1:0] nxt_out;
   // ************************************
   // Bit latches
   // ************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         latch_ff <= {W{1'b1}};
      end else if (latch_wr) begin
         latch_ff <= wdata;
      end else if (ONES_ON_BUS && bus_oe) begin
         latch_ff <= {W{1'b1}};
      end
   end
   // ************************************
   // Pin sampling
   // ************************************
   always_ff @(posedge clk_sys) begin
      meta_ff <= pin_in;
      pin_sync_ff <= meta_ff;
   end
   assign rd_value = rd_pin ? pin_sync_ff : latch_ff;
   // ************************************
   // Output stage, latch seen in phase 1
   // ************************************
   always_comb begin
      nxt_out = pin_out_ff;
      if (bus_oe) begin
         nxt_out = bus_data;
      end else if (tim.phase_one) begin
         nxt_out = latch_ff & alt_out;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pin_out_ff <= {W{1'b1}};
         pin_oe_ff <= {W{1'b0}};
      end else begin
         pin_out_ff <= nxt_out;
         pin_oe_ff <= bus_oe ? {W{1'b1}} : ~nxt_out;
      end
   end

   stuck_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!bus_oe && tim.phase_one) |=> ((pin_out_ff & ~$past(latch_ff)) == {W{1'b0}}))
      else $error("Pin not held low by cleared latch");
endmodule

// [core/ccs_top.sv]
// Cycle sequencer, fetch timing, port latches and status word
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_top #(
   parameter bit HAS_TIMER2 = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [31:0] port_pin_in,
   output logic [31:0] port_pin_out,
   output logic [31:0] port_pin_oe,
   input wire logic serial_tx_level,
   output logic ale,
   output logic code_read_n,
   output logic [7:0] p3_alt_in,
   output logic [1:0] p1_alt_in
);
   ccs_timing_if tim (.clk(clk_sys));
   ccs_pkg::ccs_run_t st_ff, nxt_st;
   logic [3:0] idx;
   logic [3:0] nxt_idx;
   logic [1:0] cyc_ff, nxt_cyc;
   logic [2:0] ncyc_ff;
   logic run_ff, two_ff;
   logic [7:0] ir_ff, operand_ff, buf_a_ff, buf_b_ff;
   logic [15:0] pc_ff, fetch_cnt_ff, dptr_ff, code_addr;
   logic [7:0] acc_ff, psw_ff;
   logic wait_ff, ale_ff, psen_n_ff;
   logic [31:0] rdata_ff, rd_mux;
   logic req, take, wr_take;
   logic [1:0] fe_cur, fe_nxt;
   logic mv_addr, mv_sig, mv_wr, mv_wide;
   logic [3:0] bus_oe, latch_wr;
   logic [31:0] bus_data, alt_out, rd_value, pin_out, pin_oe, pin_sync;
   logic [4:0] bank_base;
   logic [4:0] op_dec;
   // ************************************
   // Helpers
   // ************************************
   function automatic logic in_win(input logic [3:0] i, input logic [3:0] lo,
                                   input logic [3:0] hi);
      in_win = (i >= lo) && (i <= hi);
   endfunction
   // {fetch at S1, fetch at S4}
   function automatic logic [1:0] fetch_en(input ccs_pkg::ccs_run_t s,
                                           input logic [1:0] c, input logic r);
      logic xm;
      xm = (s == ccs_pkg::ccs_xmem);
      fetch_en = {(s != ccs_pkg::ccs_idle) && !(xm && c == 2'h1),
                  r && !(xm && c == 2'h0)};
   endfunction
   // {external_data_move, two byte, cycles}
   function automatic logic [4:0] decode_op(input logic [7:0] op);
      logic mv;
      mv = (op[7:5] == `CCS_EXTERNAL_DATA_MOVE_TOP) && (op[3:0] == 4'h0 || op[3:1] == 3'h1);
      decode_op = {1'b0, 1'b0, `CCS_CYC_ONE};
      if (op == `CCS_OP_MUL || op == `CCS_OP_DIV) begin
         decode_op[2:0] = `CCS_CYC_MULDIV;
      end else if (mv) begin
         decode_op = {1'b1, 1'b0, `CCS_CYC_LONG};
      end else if (op[3:0] == 4'h3) begin
         decode_op[2:0] = `CCS_CYC_LONG;
      end else begin
         decode_op[3] = (op[3:0] == 4'h4) || (op[3:0] == 4'h5);
      end
   endfunction
   // ************************************
   // Timing
   // ************************************
   ccs_phase_gen u_gen (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tim(tim)
   );
   assign idx = tim.phase_idx;
   assign nxt_idx = (idx == `CCS_LAST) ? 4'h0 : idx + 4'h1;
   assign op_dec = decode_op(buf_b_ff);
   always_comb begin
      nxt_st = st_ff;
      nxt_cyc = cyc_ff;
      if (idx == `CCS_S1P2 && cyc_ff == 2'h0 && st_ff != ccs_pkg::ccs_idle) begin
         nxt_st = op_dec[4] ? ccs_pkg::ccs_xmem : ccs_pkg::ccs_exec;
      end
      if (idx == `CCS_LAST) begin
         if ({1'b0, cyc_ff} >= ncyc_ff - 3'h1) begin
            nxt_cyc = 2'h0;
            nxt_st = run_ff ? ccs_pkg::ccs_exec : ccs_pkg::ccs_idle;
         end else begin
            nxt_cyc = cyc_ff + 2'h1;
         end
      end
   end
   assign fe_cur = fetch_en(st_ff, cyc_ff, run_ff);
   assign fe_nxt = fetch_en(nxt_st, nxt_cyc, run_ff);
   // ************************************
   // Instruction sequencing
   // ************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st_ff <= ccs_pkg::ccs_idle;
         cyc_ff <= 2'h0;
      end else begin
         st_ff <= nxt_st;
         cyc_ff <= nxt_cyc;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ir_ff <= 8'h00;
         ncyc_ff <= `CCS_CYC_ONE;
         two_ff <= 1'b0;
         operand_ff <= 8'h00;
         pc_ff <= 16'h0000;
      end else if (idx == `CCS_S1P2 && cyc_ff == 2'h0 && st_ff != ccs_pkg::ccs_idle) begin
         ir_ff <= buf_b_ff;
         ncyc_ff <= op_dec[2:0];
         two_ff <= op_dec[3];
         pc_ff <= pc_ff + 16'h0001;
      end else if (idx == `CCS_S4P1 && cyc_ff == 2'h0 && st_ff != ccs_pkg::ccs_idle) begin
         if (two_ff) begin
            operand_ff <= buf_a_ff;
            pc_ff <= pc_ff + 16'h0001;
         end
      end
   end
   // ************************************
   // Code fetch capture
   // ************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         buf_a_ff <= 8'h00;
         buf_b_ff <= 8'h00;
         fetch_cnt_ff <= 16'h0000;
      end else if (idx == `CCS_S3P2 && fe_cur[1]) begin
         buf_a_ff <= pin_sync[7:0];
         fetch_cnt_ff <= fetch_cnt_ff + 16'h0001;
      end else if (idx == `CCS_LAST && fe_cur[0]) begin
         buf_b_ff <= pin_sync[7:0];
         fetch_cnt_ff <= fetch_cnt_ff + 16'h0001;
      end
   end
   // ************************************
   // External bus timing
   // ************************************
   assign mv_addr = (nxt_st == ccs_pkg::ccs_xmem) && nxt_cyc == 2'h0;
   assign mv_sig = (nxt_st == ccs_pkg::ccs_xmem) && nxt_cyc == 2'h1;
   assign mv_wr = ir_ff[4];
   assign mv_wide = ~ir_ff[1];
   assign code_addr = pc_ff + {15'h0000, nxt_idx == `CCS_S1P2 && nxt_cyc == 2'h0};
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ale_ff <= 1'b0;
         psen_n_ff <= 1'b1;
      end else begin
         ale_ff <= (in_win(nxt_idx, `CCS_S1P2, `CCS_S2P1) && fe_nxt[1]) ||
                   (in_win(nxt_idx, `CCS_S4P2, `CCS_S5P1) && (fe_nxt[0] || mv_addr));
         psen_n_ff <= !((in_win(nxt_idx, 4'h3, `CCS_S3P2) && fe_nxt[1]) ||
                        (in_win(nxt_idx, 4'h9, `CCS_LAST) && fe_nxt[0]));
      end
   end
   always_comb begin
      bus_oe = 4'h0;
      bus_data = 32'hffffffff;
      if (in_win(nxt_idx, `CCS_S4P2, `CCS_S5P1) && mv_addr) begin
         bus_oe[0] = 1'b1;
         bus_data[7:0] = dptr_ff[7:0];
      end else if ((in_win(nxt_idx, 4'h9, `CCS_LAST) && mv_addr ||
                    in_win(nxt_idx, 4'h0, `CCS_SIG_END) && mv_sig) && mv_wr) begin
         bus_oe[0] = 1'b1;
         bus_data[7:0] = acc_ff;
      end else if (in_win(nxt_idx, `CCS_S1P2, `CCS_S2P1) && fe_nxt[1] ||
                   in_win(nxt_idx, `CCS_S4P2, `CCS_S5P1) && fe_nxt[0]) begin
         bus_oe[0] = 1'b1;
         bus_data[7:0] = code_addr[7:0];
      end
      if ((in_win(nxt_idx, `CCS_S4P2, `CCS_LAST) && mv_addr ||
           in_win(nxt_idx, 4'h0, `CCS_SIG_END) && mv_sig) && mv_wide) begin
         bus_oe[2] = 1'b1;
         bus_data[23:16] = dptr_ff[15:8];
      end else if (in_win(nxt_idx, `CCS_S1P2, `CCS_S3P2) && fe_nxt[1] ||
                   in_win(nxt_idx, `CCS_S4P2, `CCS_LAST) && fe_nxt[0]) begin
         bus_oe[2] = 1'b1;
         bus_data[23:16] = code_addr[15:8];
      end
   end
   // Port 3: rx, tx, external_interrupt_zero, external_interrupt_one, t0, t1, write strobe, read strobe
   always_comb begin
      alt_out = 32'hffffffff;
      alt_out[25] = serial_tx_level;
      if (st_ff == ccs_pkg::ccs_xmem && cyc_ff == 2'h1 && idx <= `CCS_S3P2) begin
         alt_out[30] = ~mv_wr;
         alt_out[31] = mv_wr;
      end
   end
   // ************************************
   // Ports
   // ************************************
   generate
      for (genvar k = 0; k < 4; k++) begin : g_port
         ccs_port #(.W(8), .ONES_ON_BUS(k == 0)) u_port (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .tim(tim),
            .latch_wr(latch_wr[k]),
            .wdata(avs_writedata[8*k+7:8*k]),
            .rd_pin(avs_address == `CCS_R_PIN),
            .bus_oe(bus_oe[k]),
            .bus_data(bus_data[8*k+7:8*k]),
            .alt_out(alt_out[8*k+7:8*k]),
            .pin_in(port_pin_in[8*k+7:8*k]),
            .pin_out_ff(pin_out[8*k+7:8*k]),
            .pin_oe_ff(pin_oe[8*k+7:8*k]),
            .pin_sync_ff(pin_sync[8*k+7:8*k]),
            .rd_value(rd_value[8*k+7:8*k])
         );
         assign latch_wr[k] = wr_take && avs_address == `CCS_R_LATCH && avs_byteenable[k];
      end
   endgenerate
   assign port_pin_out = pin_out;
   assign port_pin_oe = pin_oe;
   assign p3_alt_in = pin_sync[31:24];
   assign p1_alt_in = HAS_TIMER2 ? pin_sync[9:8] : 2'h0;
   // ************************************
   // Data path and status word
   // ************************************
   assign bank_base = {psw_ff[4:3], 3'h0};
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         acc_ff <= 8'h00;
      end else if (st_ff == ccs_pkg::ccs_xmem && cyc_ff == 2'h1 && idx == `CCS_S3P2 &&
                   !mv_wr) begin
         acc_ff <= pin_sync[7:0];
      end else if (wr_take && avs_address == `CCS_R_ACC && avs_byteenable[0]) begin
         acc_ff <= avs_writedata[7:0];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         psw_ff <= `CCS_PSW_RST;
      end else begin
         if (wr_take && avs_address == `CCS_R_PSW && avs_byteenable[0]) begin
            psw_ff[7:2] <= avs_writedata[7:2];
         end
         if (idx == `CCS_S6P1) begin
            psw_ff[0] <= ^acc_ff;
         end
      end
   end
   // ************************************
   // Register bus
   // ************************************
   assign req = avs_read | avs_write;
   assign take = req && !wait_ff;
   assign wr_take = take && avs_write;
   always_comb begin
      case (avs_address)
         `CCS_R_CTRL: rd_mux = {31'h0, run_ff};
         `CCS_R_STAT: rd_mux = {4'h0, bank_base, ir_ff, 3'h0, st_ff, cyc_ff,
                                tim.state_num, idx};
         `CCS_R_PSW: rd_mux = {24'h0, (psw_ff & `CCS_PSW_WMASK) | {7'h00, psw_ff[0]}};
         `CCS_R_ACC: rd_mux = {16'h0, operand_ff, acc_ff};
         `CCS_R_DPTR: rd_mux = {16'h0, dptr_ff};
         `CCS_R_LATCH, `CCS_R_PIN: rd_mux = rd_value;
         `CCS_R_PC: rd_mux = {fetch_cnt_ff, pc_ff};
         default: rd_mux = 32'h0;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0;
      end else begin
         wait_ff <= !(req && wait_ff);
         if (avs_read && wait_ff) begin
            rdata_ff <= rd_mux;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         run_ff <= 1'b0;
         dptr_ff <= 16'h0;
      end else if (wr_take && avs_address == `CCS_R_CTRL && avs_byteenable[0]) begin
         run_ff <= avs_writedata[0];
      end else if (wr_take && avs_address == `CCS_R_DPTR) begin
         dptr_ff <= avs_writedata[15:0];
      end
   end
   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign ale = ale_ff;
   assign code_read_n = psen_n_ff;
   // ************************************
   // Checks
   // ************************************
   sequence ale_pulse_s;
      ale_ff ##1 ale_ff ##1 !ale_ff;
   endsequence
   sequence ir_slot_s;
      idx == `CCS_S1P2 && cyc_ff == 2'h0 && st_ff != ccs_pkg::ccs_idle;
   endsequence
   ale_slot_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ale_ff |-> (idx == 4'h1 || idx == 4'h2 || idx == 4'h7 || idx == 4'h8))
      else $error("Address strobe outside its slots");
   ale_width_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(ale_ff) |-> ale_pulse_s)
      else $error("Address strobe not two periods");
   ir_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ir_slot_s |=> ir_ff == $past(buf_b_ff))
      else $error("Opcode not captured at S1P2");
   one_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (idx == `CCS_S4P1 && cyc_ff == 2'h0 && !two_ff) |=> $stable(pc_ff))
      else $error("Counter moved on one-byte fetch");
   two_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (idx == `CCS_S4P1 && cyc_ff == 2'h0 && two_ff && st_ff != ccs_pkg::ccs_idle)
      |=> pc_ff == $past(pc_ff) + 16'h0001)
      else $error("Second byte not taken at S4");
   cyc_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(cyc_ff) |-> $past(idx) == `CCS_LAST)
      else $error("Cycle changed before S6P2");
   muldiv_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ir_slot_s and (buf_b_ff == `CCS_OP_MUL)) |-> ##[1:40] cyc_ff == 2'h3)
      else $error("Multiply not four cycles");
   external_data_move_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_ff == ccs_pkg::ccs_xmem && cyc_ff == 2'h1) |-> !(ale_ff && idx <= 4'h2))
      else $error("Fetch not skipped in data move");
   parity_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      idx == `CCS_S6P1 |=> psw_ff[0] == ^$past(acc_ff))
      else $error("Parity bit wrong");
endmodule

// [verification/ccs_mem_model.sv]
// External code and data memory model seen from the pins
`timescale 1ns/1ps
module ccs_mem_model (
   input wire logic clk_sys,
   input wire logic ale,
   input wire logic code_read_n,
   input wire logic data_rd_n,
   input wire logic [7:0] code_byte,
   output logic drv_en,
   output logic [7:0] drv_data,
   output logic [15:0] ale_count = 16'h0,
   output logic [15:0] read_count = 16'h0
);
   // ************************************
   // Bus drive and strobe counters
   // ************************************
   logic ale_d = 1'b0;
   logic rd_d = 1'b1;
   // Memory answers on port 0 while a code or data read strobe is low
   assign drv_en = ~code_read_n | ~data_rd_n;
   assign drv_data = code_byte;
   always @(posedge clk_sys) begin
      ale_d <= ale;
      rd_d <= code_read_n;
      if (ale && !ale_d) begin
         ale_count <= ale_count + 16'h1;
      end
      if (!code_read_n && rd_d) begin
         read_count <= read_count + 16'h1;
      end
   end
endmodule

// [verification/cpu_cycle_sequencer_ports_test.sv]
// Register bus test of the cycle sequencer with a memory model
`timescale 1ns/1ps
`include "ccs_params.svh"
`define CHECK_EQ(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
   $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module cpu_cycle_sequencer_ports_test;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic serial_tx_level = 1'b1;
   logic [7:0] code_byte = 8'h00;
   logic [31:0] ext_low = 32'h0;
   logic [31:0] avs_readdata, port_pin_out, port_pin_oe, pin_lvl, rd, pc0;
   logic avs_waitrequest, ale, code_read_n, mem_en;
   logic [7:0] p3_alt_in, mem_data;
   logic [1:0] p1_alt_in;
   logic [15:0] ale_cnt, rd_cnt, a0, r0;
   logic [7:0] ops [4] = '{8'h00, 8'h04, 8'ha4, 8'he0};
   logic [15:0] fx [4] = '{16'h28, 16'h28, 16'h28, 16'h14};
   logic [15:0] pcx [4] = '{16'h14, 16'h28, 16'h5, 16'ha};
   // A data move skips one address strobe in its second cycle
   logic [15:0] alx [4] = '{16'h28, 16'h28, 16'h28, 16'h1e};
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   always #5 clk_sys = ~clk_sys;
   // Released lines are pulled high unless the memory drives port 0; an outside source may pull them low
   assign pin_lvl = ((port_pin_oe & port_pin_out)
      | (~port_pin_oe & {24'hffffff, mem_en ? mem_data : 8'hff})) & ~ext_low;
   ccs_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .port_pin_in(pin_lvl),
      .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
      .serial_tx_level(serial_tx_level), .ale(ale), .code_read_n(code_read_n),
      .p3_alt_in(p3_alt_in), .p1_alt_in(p1_alt_in));
   ccs_mem_model u_mem (.clk_sys(clk_sys), .ale(ale), .code_read_n(code_read_n),
      .data_rd_n(pin_lvl[31]), .code_byte(code_byte), .drv_en(mem_en),
      .drv_data(mem_data), .ale_count(ale_cnt), .read_count(rd_cnt));
   // ************************************
   // Bus tasks
   // ************************************
   task automatic stop_test;
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wait_ack;
      int n;
      n = 0;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      `CHECK_EQ(n, 1)
   endtask
   task automatic av_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic av_read(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end
   // ************************************
   // Tests
   // ************************************
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      av_read(`CCS_R_LATCH, rd);
      `CHECK_EQ(rd, 32'hffffffff)
      av_read(`CCS_R_PSW, rd);
      `CHECK_EQ(rd, 32'h00000000)
      av_write(4'ha, 32'h12345678, 4'hf);
      av_read(4'ha, rd);
      `CHECK_EQ(rd, 32'h00000000)
      av_write(`CCS_R_LATCH, 32'h00000f00, 4'h2);
      ext_low <= 32'h00000100;
      repeat (6) @(posedge clk_sys);
      av_read(`CCS_R_LATCH, rd);
      `CHECK_EQ(rd, 32'hffff0fff)
      av_read(`CCS_R_PIN, rd);
      `CHECK_EQ(rd, 32'hffff0eff)
      `CHECK_EQ(p1_alt_in, 2'h2)
      av_write(`CCS_R_LATCH, 32'hfd000000, 4'h8);
      repeat (6) @(posedge clk_sys);
      `CHECK_EQ(pin_lvl[25], 1'b0)
      av_write(`CCS_R_LATCH, 32'hff000000, 4'h8);
      serial_tx_level <= 1'b0;
      repeat (6) @(posedge clk_sys);
      `CHECK_EQ(pin_lvl[25], 1'b0)
      serial_tx_level <= 1'b1;
      repeat (6) @(posedge clk_sys);
      `CHECK_EQ(pin_lvl[25], 1'b1)
      `CHECK_EQ(p3_alt_in[1], 1'b1)
      av_write(`CCS_R_ACC, 32'h00000007, 4'h1);
      av_write(`CCS_R_PSW, 32'h00000012, 4'h1);
      repeat (24) @(posedge clk_sys);
      av_read(`CCS_R_PSW, rd);
      `CHECK_EQ(rd, 32'h00000011)
      av_read(`CCS_R_STAT, rd);
      `CHECK_EQ(rd[27:23], 5'h10)
      for (int i = 0; i < 4; i++) begin
         code_byte <= ops[i];
         if (i == 0) begin
            av_write(`CCS_R_CTRL, 32'h00000001, 4'h1);
         end
         repeat (96) @(posedge clk_sys);
         av_read(`CCS_R_PC, pc0);
         a0 = ale_cnt;
         r0 = rd_cnt;
         repeat (237) @(posedge clk_sys);
         av_read(`CCS_R_PC, rd);
         `CHECK_EQ(16'(rd[31:16] - pc0[31:16]), fx[i])
         `CHECK_EQ(16'(rd_cnt - r0), fx[i])
         `CHECK_EQ(16'(ale_cnt - a0), alx[i])
         if (pcx[i] != 16'h0) begin
            `CHECK_EQ(16'(rd[15:0] - pc0[15:0]), pcx[i])
         end
      end
      stop_test();
   end
endmodule
